// ### ddr2_core_defs.svh
`ifndef DDR2_CORE_DEFS_SVH
`define DDR2_CORE_DEFS_SVH

`define CLK_PERIOD_NS            100
`define MIN_ROW_ACTIVE_TIME_NS   45
`define ROW_PRECHARGE_TIME_NS    15
`define READ_TO_PRECHARGE_TIME_NS 8
`define WRITE_RECOVERY_TIME_NS   15
`define MIN_ROW_ACTIVE_CYC       ((`MIN_ROW_ACTIVE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ROW_PRECHARGE_CYC        ((`ROW_PRECHARGE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_TO_PRECHARGE_CYC    ((`READ_TO_PRECHARGE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_RECOVERY_CYC       ((`WRITE_RECOVERY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define PRECHARGE_SELECT_POS     10
`define MODE_BL_LSB              0
`define MODE_BL_MSB              2
`define MODE_BURST_TYPE_POS      3
`define MODE_CL_LSB              4
`define MODE_CL_MSB              6
`define MODE_WR_LSB              9
`define MODE_WR_MSB              11
`define EXT_AL_LSB               3
`define EXT_AL_MSB               5
`define MODE_BL_CODE_FOUR        3'h2
`define MODE_BL_CODE_EIGHT       3'h3
`define MODE_BANK_CODE           2'h0
`define EXT_MODE_BANK_CODE       2'h1

`define RESET_BURST_EIGHT        1'h0
`define RESET_BURST_INTERLEAVE   1'h0
`define RESET_COLUMN_LATENCY     3'h3
`define RESET_ADDITIVE_LATENCY   3'h0
`define RESET_WRITE_RECOVERY     3'h2
`define BURST_INTERRUPT_GAP      8'h02
`define CNT_W                    8

`endif

// ### ddr2_core_pkg.sv
package ddr2_core_pkg;

  typedef struct packed {
    logic        cs_b;
    logic        ras_b;
    logic        cas_b;
    logic        we_b;
    logic        bank_select_high;
    logic        bank_select_low;
    logic [13:0] addr;
  } cmd_s;

  typedef struct packed {
    logic       burst_eight;
    logic       burst_interleave;
    logic [2:0] column_latency;
    logic [2:0] additive_latency;
    logic [2:0] write_recovery;
  } mode_s;

  typedef enum logic [2:0] {
    BURST_IDLE  = 3'h1,
    BURST_READ  = 3'h2,
    BURST_WRITE = 3'h4
  } burst_state_e;

endpackage

// ### bank_timer.sv
`timescale 1ns/10ps
`include "ddr2_core_defs.svh"

module bank_timer #(
  parameter int CNT_W    = `CNT_W,
  parameter int MIN_ROW_ACTIVE_TIME_CYC = `MIN_ROW_ACTIVE_CYC,
  parameter int TRP_CYC  = `ROW_PRECHARGE_CYC
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             act,
  input  wire logic             rd,
  input  wire logic             wr,
  input  wire logic             pre,
  input  wire logic             auto_pre,
  input  wire logic [CNT_W-1:0] rd_ap_delay,
  input  wire logic [CNT_W-1:0] rtp_delay,
  input  wire logic [CNT_W-1:0] wr_ap_delay,
  output logic                  open_reg,
  output logic                  precharging,
  output logic                  ap_armed_reg,
  output logic                  recovering
);
  localparam logic [CNT_W-1:0] MIN_ROW_ACTIVE_TIME_LOAD = CNT_W'(MIN_ROW_ACTIVE_TIME_CYC);
  localparam logic [CNT_W-1:0] TRP_LOAD  = CNT_W'(TRP_CYC);

  logic [CNT_W-1:0] min_row_active_time_cnt_reg;
  logic [CNT_W-1:0] trp_cnt_reg;
  logic [CNT_W-1:0] ap_cnt_reg;
  logic [CNT_W-1:0] rtp_cnt_reg;
  logic [CNT_W-1:0] wrec_cnt_reg;
  logic             pend_reg;
  logic             fire;

  assign fire = open_reg && (min_row_active_time_cnt_reg == '0) &&
                (pend_reg || pre || (ap_armed_reg && ap_cnt_reg == '0 && rtp_cnt_reg == '0));
  assign precharging = (trp_cnt_reg != '0);
  assign recovering  = (wrec_cnt_reg != '0);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      open_reg     <= 1'b0;
      min_row_active_time_cnt_reg <= '0;
    end else if (act) begin
      open_reg     <= 1'b1;
      min_row_active_time_cnt_reg <= MIN_ROW_ACTIVE_TIME_LOAD;
    end else begin
      if (fire) begin
        open_reg <= 1'b0;
      end
      if (min_row_active_time_cnt_reg != '0) begin
        min_row_active_time_cnt_reg <= min_row_active_time_cnt_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trp_cnt_reg <= '0;
    end else if (fire) begin
      trp_cnt_reg <= TRP_LOAD;
    end else if (trp_cnt_reg != '0) begin
      trp_cnt_reg <= trp_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg <= 1'b0;
    end else if (fire || act) begin
      pend_reg <= 1'b0;
    end else if (pre && open_reg) begin
      pend_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ap_armed_reg <= 1'b0;
      ap_cnt_reg   <= '0;
      rtp_cnt_reg  <= '0;
    end else if ((rd || wr) && auto_pre) begin
      ap_armed_reg <= 1'b1;
      ap_cnt_reg   <= rd ? rd_ap_delay : wr_ap_delay;
      rtp_cnt_reg  <= rd ? rtp_delay : '0;
    end else begin
      if (fire || act) begin
        ap_armed_reg <= 1'b0;
      end
      if (ap_cnt_reg != '0) begin
        ap_cnt_reg <= ap_cnt_reg - 1'b1;
      end
      if (rtp_cnt_reg != '0) begin
        rtp_cnt_reg <= rtp_cnt_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrec_cnt_reg <= '0;
    end else if (wr) begin
      wrec_cnt_reg <= wr_ap_delay;
    end else if (wrec_cnt_reg != '0) begin
      wrec_cnt_reg <= wrec_cnt_reg - 1'b1;
    end
  end

endmodule

// ### ddr2_burst_interrupt_precharge.sv
`timescale 1ns/10ps
`include "ddr2_core_defs.svh"

module ddr2_burst_interrupt_precharge #(
  parameter int BANKS    = 4,
  parameter int CNT_W    = `CNT_W,
  parameter int MIN_ROW_ACTIVE_TIME_CYC = `MIN_ROW_ACTIVE_CYC,
  parameter int TRP_CYC  = `ROW_PRECHARGE_CYC,
  parameter int READ_TO_PRECHARGE_TIME_CYC = `READ_TO_PRECHARGE_CYC,
  parameter int TWR_CYC  = `WRITE_RECOVERY_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  ddr2_core_pkg::cmd_s       cmd,
  output ddr2_core_pkg::mode_s      mode_reg,
  output logic [3:0]                read_latency_reg,
  output logic [3:0]                write_latency_reg,
  output logic [BANKS-1:0]          bank_open_reg,
  output logic [BANKS-1:0]          bank_precharging_reg,
  output logic                      read_burst_reg,
  output logic                      write_burst_reg,
  output logic                      burst_interrupted_reg,
  output logic                      command_violation_reg
);
  localparam logic [CNT_W-1:0] READ_TO_PRECHARGE_TIME_LOAD = CNT_W'(READ_TO_PRECHARGE_TIME_CYC);
  localparam logic [CNT_W-1:0] TWR_LOAD  = CNT_W'(TWR_CYC);

  logic                  cmd_sel;
  logic                  is_act;
  logic                  is_rd;
  logic                  is_wr;
  logic                  is_pre;
  logic                  is_mrs;
  logic                  precharge_select_bit;
  logic [1:0]            bank_idx;
  logic [BANKS-1:0]      bank_hit;
  logic [BANKS-1:0]      act_v;
  logic [BANKS-1:0]      rd_v;
  logic [BANKS-1:0]      wr_v;
  logic [BANKS-1:0]      pre_v;
  logic [BANKS-1:0]      open_v;
  logic [BANKS-1:0]      prech_v;
  logic [BANKS-1:0]      armed_v;
  logic [BANKS-1:0]      recov_v;
  logic [CNT_W-1:0]      half_bl;
  logic [CNT_W-1:0]      al_cnt;
  logic [CNT_W-1:0]      wl_cnt;
  logic [CNT_W-1:0]      rd_ap_delay;
  logic [CNT_W-1:0]      rtp_delay;
  logic [CNT_W-1:0]      wr_ap_delay;
  logic [CNT_W-1:0]      burst_cnt_reg;
  logic [CNT_W-1:0]      since_cmd_reg;
  logic                  burst_ap_reg;
  logic                  violation;
  logic                  burst_live;
  ddr2_core_pkg::burst_state_e burst_state_reg;
  ddr2_core_pkg::burst_state_e burst_state_next;

  assign cmd_sel = !cmd.cs_b;
  assign is_act  = cmd_sel && !cmd.ras_b &&  cmd.cas_b &&  cmd.we_b;
  assign is_rd   = cmd_sel &&  cmd.ras_b && !cmd.cas_b &&  cmd.we_b;
  assign is_wr   = cmd_sel &&  cmd.ras_b && !cmd.cas_b && !cmd.we_b;
  assign is_pre  = cmd_sel && !cmd.ras_b &&  cmd.cas_b && !cmd.we_b;
  assign is_mrs  = cmd_sel && !cmd.ras_b && !cmd.cas_b && !cmd.we_b;
  assign precharge_select_bit = cmd.addr[`PRECHARGE_SELECT_POS];
  assign bank_idx = {cmd.bank_select_high, cmd.bank_select_low};

  always_comb begin
    bank_hit = '0;
    bank_hit[bank_idx] = 1'b1;
    pre_v = is_pre ? (precharge_select_bit ? {BANKS{1'b1}} : bank_hit) : '0;
  end
  // any bank may be the target
  assign act_v = is_act ? bank_hit : '0;
  assign rd_v  = is_rd  ? bank_hit : '0;
  assign wr_v  = is_wr  ? bank_hit : '0;

  // delays from the programmed burst length
  assign half_bl = mode_reg.burst_eight ? CNT_W'(4) : CNT_W'(2);
  assign al_cnt  = CNT_W'(mode_reg.additive_latency);
  assign wl_cnt  = CNT_W'(write_latency_reg);
  // second prefetch at two clocks for burst eight
  assign rd_ap_delay = al_cnt + half_bl;
  assign rtp_delay = al_cnt + (mode_reg.burst_eight ? CNT_W'(2) : CNT_W'(0)) + READ_TO_PRECHARGE_TIME_LOAD;
  assign wr_ap_delay = wl_cnt + half_bl + TWR_LOAD + CNT_W'(mode_reg.write_recovery) - CNT_W'(1);

  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_bank
      bank_timer #(
        .CNT_W    (CNT_W),
        .MIN_ROW_ACTIVE_TIME_CYC (MIN_ROW_ACTIVE_TIME_CYC),
        .TRP_CYC  (TRP_CYC)
      ) u_bank (
        .clk          (clk),
        .rst_b        (rst_b),
        .act          (act_v[b]),
        .rd           (rd_v[b]),
        .wr           (wr_v[b]),
        .pre          (pre_v[b]),
        .auto_pre     (precharge_select_bit),
        .rd_ap_delay  (rd_ap_delay),
        .rtp_delay    (rtp_delay),
        .wr_ap_delay  (wr_ap_delay),
        .open_reg     (open_v[b]),
        .precharging  (prech_v[b]),
        .ap_armed_reg (armed_v[b]),
        .recovering   (recov_v[b])
      );
    end
  endgenerate

  // mode register fields
  // one process owns the whole struct so no field has two writers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg.burst_eight      <= `RESET_BURST_EIGHT;
      mode_reg.burst_interleave <= `RESET_BURST_INTERLEAVE;
      mode_reg.column_latency   <= `RESET_COLUMN_LATENCY;
      mode_reg.write_recovery   <= `RESET_WRITE_RECOVERY;
      mode_reg.additive_latency <= `RESET_ADDITIVE_LATENCY;
    end else if (is_mrs && bank_idx == `MODE_BANK_CODE) begin
      mode_reg.burst_eight      <= (cmd.addr[`MODE_BL_MSB:`MODE_BL_LSB] == `MODE_BL_CODE_EIGHT);
      mode_reg.burst_interleave <= cmd.addr[`MODE_BURST_TYPE_POS];
      mode_reg.column_latency   <= cmd.addr[`MODE_CL_MSB:`MODE_CL_LSB];
      mode_reg.write_recovery   <= cmd.addr[`MODE_WR_MSB:`MODE_WR_LSB];
    end else if (is_mrs && bank_idx == `EXT_MODE_BANK_CODE) begin
      mode_reg.additive_latency <= cmd.addr[`EXT_AL_MSB:`EXT_AL_LSB];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      read_latency_reg  <= 4'h3;
      write_latency_reg <= 4'h2;
    end else begin
      read_latency_reg  <= 4'(mode_reg.additive_latency) + 4'(mode_reg.column_latency);
      write_latency_reg <= 4'(mode_reg.additive_latency) + 4'(mode_reg.column_latency) - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bank_open_reg        <= '0;
      bank_precharging_reg <= '0;
    end else begin
      bank_open_reg        <= open_v;
      bank_precharging_reg <= prech_v;
    end
  end

  always_comb begin
    burst_state_next = burst_state_reg;
    if (is_rd) begin
      burst_state_next = ddr2_core_pkg::BURST_READ;
    end else if (is_wr) begin
      burst_state_next = ddr2_core_pkg::BURST_WRITE;
    end else if (burst_cnt_reg <= CNT_W'(1)) begin
      burst_state_next = ddr2_core_pkg::BURST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      burst_state_reg <= ddr2_core_pkg::BURST_IDLE;
      burst_cnt_reg   <= '0;
      since_cmd_reg   <= '0;
      burst_ap_reg    <= 1'b0;
    end else begin
      burst_state_reg <= burst_state_next;
      if (is_rd || is_wr) begin
        burst_cnt_reg <= half_bl;
        since_cmd_reg <= CNT_W'(1);
        burst_ap_reg  <= precharge_select_bit;
      end else begin
        if (burst_cnt_reg != '0) begin
          burst_cnt_reg <= burst_cnt_reg - 1'b1;
        end
        if (since_cmd_reg != '1) begin
          since_cmd_reg <= since_cmd_reg + 1'b1;
        end
      end
    end
  end

  // the slot BL/2 clocks after a command is seamless, not an interruption
  assign burst_live = (burst_cnt_reg > CNT_W'(1));

  // a flagged command is still executed; the flag only reports controller misuse
  always_comb begin
    violation = 1'b0;
    if (burst_live) begin
      unique case (burst_state_reg)
        ddr2_core_pkg::BURST_IDLE: begin
          violation = 1'b0;
        end
        ddr2_core_pkg::BURST_READ: begin
          // read burst cut only by read
          if (is_wr || is_pre) violation = 1'b1;
          if (is_rd && !mode_reg.burst_eight) violation = 1'b1;
          if (is_rd && since_cmd_reg != `BURST_INTERRUPT_GAP) violation = 1'b1;
          if (is_rd && burst_ap_reg) violation = 1'b1;
        end
        ddr2_core_pkg::BURST_WRITE: begin
          // write burst cut only by write
          if (is_rd || is_pre) violation = 1'b1;
          if (is_wr && !mode_reg.burst_eight) violation = 1'b1;
          if (is_wr && since_cmd_reg != `BURST_INTERRUPT_GAP) violation = 1'b1;
          if (is_wr && burst_ap_reg) violation = 1'b1;
        end
      endcase
    end
    if (|(pre_v & recov_v)) violation = 1'b1;
    if (|(act_v & (open_v | prech_v))) violation = 1'b1;
    // command to bank with pending auto-precharge
    if (|((act_v | rd_v | wr_v) & armed_v)) violation = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      read_burst_reg        <= 1'b0;
      write_burst_reg       <= 1'b0;
      burst_interrupted_reg <= 1'b0;
      command_violation_reg <= 1'b0;
    end else begin
      read_burst_reg        <= (burst_state_next == ddr2_core_pkg::BURST_READ);
      write_burst_reg       <= (burst_state_next == ddr2_core_pkg::BURST_WRITE);
      burst_interrupted_reg <= burst_live &&
                               ((is_rd && burst_state_reg == ddr2_core_pkg::BURST_READ) ||
                                (is_wr && burst_state_reg == ddr2_core_pkg::BURST_WRITE));
      command_violation_reg <= violation;
    end
  end

endmodule

// ### ddr2_burst_interrupt_precharge_asserts.sv
`timescale 1ns/10ps
module ddr2_burst_interrupt_precharge_asserts #(
  parameter int BANKS = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  ddr2_core_pkg::cmd_s   cmd,
  input  ddr2_core_pkg::mode_s  mode_reg,
  input  wire logic [3:0]       read_latency_reg,
  input  wire logic [3:0]       write_latency_reg,
  input  wire logic [BANKS-1:0] bank_open_reg,
  input  wire logic [BANKS-1:0] bank_precharging_reg,
  input  wire logic             read_burst_reg,
  input  wire logic             write_burst_reg,
  input  wire logic             burst_interrupted_reg,
  input  wire logic             command_violation_reg
);
  logic       is_nop;
  logic       is_rd;
  logic       is_wr;
  logic       is_pre;
  logic       is_act;
  logic       ap;
  logic [1:0] bank;
  assign is_nop = cmd.cs_b;
  assign is_rd  = !cmd.cs_b && cmd.ras_b && !cmd.cas_b && cmd.we_b;
  assign is_wr  = !cmd.cs_b && cmd.ras_b && !cmd.cas_b && !cmd.we_b;
  assign is_pre = !cmd.cs_b && !cmd.ras_b && cmd.cas_b && !cmd.we_b;
  assign is_act = !cmd.cs_b && !cmd.ras_b && cmd.cas_b && cmd.we_b;
  assign ap     = cmd.addr[10];
  assign bank   = {cmd.bank_select_high, cmd.bank_select_low};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // pulses may land one or two edges after the command, hence the short ranges
  sequence s_rd8_gap2; is_rd && mode_reg.burst_eight ##1 is_nop ##1 1'b1; endsequence
  sequence s_wr8_gap2; is_wr && mode_reg.burst_eight ##1 is_nop ##1 1'b1; endsequence
  property p_rl; 1'b1 |-> read_latency_reg == 4'($past(mode_reg.additive_latency)) + 4'($past(mode_reg.column_latency));
  endproperty
  property p_wl; 1'b1 |-> write_latency_reg == read_latency_reg - 4'h1; endproperty
  property p_rd_intr; (!ap ##0 s_rd8_gap2) ##0 is_rd |-> ##[1:2] burst_interrupted_reg; endproperty
  property p_wr_intr; (!ap ##0 s_wr8_gap2) ##0 is_wr |-> ##[1:2] burst_interrupted_reg; endproperty
  property p_rd_close; is_rd ##1 is_rd |-> ##[1:2] command_violation_reg; endproperty
  property p_rd_other; s_rd8_gap2 ##0 (is_wr || is_pre) |-> ##[1:2] command_violation_reg; endproperty
  property p_wr_other; s_wr8_gap2 ##0 (is_rd || is_pre) |-> ##[1:2] command_violation_reg; endproperty
  property p_ap_intr; (ap ##0 s_rd8_gap2) ##0 is_rd |-> ##[1:2] command_violation_reg; endproperty
  property p_pre_all; is_pre && ap ##1 (!is_act)[*3] |-> bank_open_reg == '0; endproperty
  property p_pre_one; is_pre && !ap ##1 (!is_act)[*3] |-> !bank_open_reg[$past(bank, 3)]; endproperty
  property p_rd_ap; is_rd && ap ##1 (!is_act)[*8] ##1 (!is_act)[*6] |-> !bank_open_reg[$past(bank, 14)]; endproperty
  property p_burst; is_rd ##1 is_nop[*7] |-> !read_burst_reg; endproperty
  a_rl: assert property (p_rl) else $error("read latency off");
  a_wl: assert property (p_wl) else $error("write latency off");
  a_rd_intr: assert property (p_rd_intr) else $error("read interrupt missed");
  a_wr_intr: assert property (p_wr_intr) else $error("write interrupt missed");
  a_rd_close: assert property (p_rd_close) else $error("close read pair not flagged");
  a_rd_other: assert property (p_rd_other) else $error("read burst cut not flagged");
  a_wr_other: assert property (p_wr_other) else $error("write burst cut not flagged");
  a_ap_intr: assert property (p_ap_intr) else $error("auto close burst cut not flagged");
  a_pre_all: assert property (p_pre_all) else $error("bank left open");
  a_pre_one: assert property (p_pre_one) else $error("selected bank left open");
  a_rd_ap: assert property (p_rd_ap) else $error("auto close missing");
  a_burst: assert property (p_burst) else $error("read burst too long");
endmodule

bind ddr2_burst_interrupt_precharge ddr2_burst_interrupt_precharge_asserts #(.BANKS(BANKS)) u_asserts (
  .clk(clk), .rst_b(rst_b), .cmd(cmd), .mode_reg(mode_reg), .read_latency_reg(read_latency_reg),
  .write_latency_reg(write_latency_reg), .bank_open_reg(bank_open_reg),
  .bank_precharging_reg(bank_precharging_reg), .read_burst_reg(read_burst_reg),
  .write_burst_reg(write_burst_reg), .burst_interrupted_reg(burst_interrupted_reg),
  .command_violation_reg(command_violation_reg));

// ### mem_ctrl_model.sv
`timescale 1ns/10ps
module mem_ctrl_model (
  input  wire logic           clk,
  output ddr2_core_pkg::cmd_s cmd
);
  initial cmd = 20'h80000;
  // deselect between commands
  // idle lines flip each cycle so a stale command never looks live
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      #1 cmd = {1'b1, ~cmd[18:0]};
    end
  endtask
  task automatic issue(input logic [3:0] kind, input logic [1:0] bank, input logic [13:0] addr);
    @(posedge clk);
    #1 cmd = {kind, bank, addr};
  endtask
endmodule

// ### ddr2_burst_interrupt_precharge_test.sv
`timescale 1ns/10ps
module ddr2_burst_interrupt_precharge_test;
  localparam logic [3:0]  K_ACT = 4'h3;
  localparam logic [3:0]  K_RD  = 4'h5;
  localparam logic [3:0]  K_WR  = 4'h4;
  localparam logic [3:0]  K_PRE = 4'h2;
  localparam logic [3:0]  K_MRS = 4'h0;
  localparam logic [13:0] AP    = 14'h0400;
  localparam logic [13:0] NA    = 14'h0000;
  logic                 clk = 1'b0;
  logic                 rst_b = 1'b0;
  ddr2_core_pkg::cmd_s  cmd;
  ddr2_core_pkg::mode_s mode_reg;
  ddr2_core_pkg::mode_s mode_exp;
  logic [3:0]           read_latency_reg;
  logic [3:0]           write_latency_reg;
  logic [3:0]           bank_open_reg;
  logic [3:0]           bank_precharging_reg;
  logic                 read_burst_reg;
  logic                 write_burst_reg;
  logic                 burst_interrupted_reg;
  logic                 command_violation_reg;
  logic                 viol_seen = 1'b0;
  logic                 intr_seen = 1'b0;
  int                   miscompares = 0;
  int                   n_tests = 0;
  int                   cycles = 0;

  always #50 clk = ~clk;

  ddr2_burst_interrupt_precharge dut (
    .clk(clk), .rst_b(rst_b), .cmd(cmd), .mode_reg(mode_reg), .read_latency_reg(read_latency_reg),
    .write_latency_reg(write_latency_reg), .bank_open_reg(bank_open_reg),
    .bank_precharging_reg(bank_precharging_reg), .read_burst_reg(read_burst_reg),
    .write_burst_reg(write_burst_reg), .burst_interrupted_reg(burst_interrupted_reg),
    .command_violation_reg(command_violation_reg));
  mem_ctrl_model ctrl (.clk(clk), .cmd(cmd));

  // pulses are caught sticky so their exact edge does not matter
  always @(negedge clk) begin
    if (command_violation_reg === 1'b1) viol_seen = 1'b1;
    if (burst_interrupted_reg === 1'b1) intr_seen = 1'b1;
  end

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic open_all();
    for (int b = 0; b < 4; b++) ctrl.issue(K_ACT, 2'(b), NA);
    ctrl.idle(3);
  endtask

  // first command always to bank 0; gap counts clocks between the two commands
  task automatic run_case(input logic [3:0] k1, input logic [13:0] a1, input int gap, input logic [3:0] k2,
                          input logic [1:0] b2, input logic [13:0] a2, input logic ev, input logic ei);
    viol_seen = 1'b0;
    intr_seen = 1'b0;
    ctrl.issue(k1, 2'h0, a1);
    if (gap > 1) ctrl.idle(gap - 1);
    ctrl.issue(k2, b2, a2);
    ctrl.idle(16);
    check(viol_seen, ev);
    if (ev === 1'b0) check(intr_seen, ei);
  endtask

  task automatic t_mode();
    mode_exp = '{1'b0, 1'b0, 3'h3, 3'h0, 3'h2};
    check(32'(mode_reg), 32'(mode_exp));
    check(read_latency_reg, 4'h3);
    ctrl.issue(K_MRS, 2'h0, 14'h065B);
    ctrl.issue(K_MRS, 2'h1, 14'h0010);
    ctrl.idle(4);
    mode_exp = '{1'b1, 1'b1, 3'h5, 3'h2, 3'h3};
    check(32'(mode_reg), 32'(mode_exp));
    check(read_latency_reg, 4'h7);
    check(write_latency_reg, 4'h6);
    ctrl.issue(K_MRS, 2'h0, 14'h0443);
    ctrl.issue(K_MRS, 2'h1, 14'h0008);
    ctrl.idle(4);
    mode_exp = '{1'b1, 1'b0, 3'h4, 3'h1, 3'h2};
    check(32'(mode_reg), 32'(mode_exp));
    check(read_latency_reg, 4'h5);
    check(write_latency_reg, 4'h4);
  endtask

  task automatic t_precharge();
    viol_seen = 1'b0;
    for (int b = 0; b < 4; b++) begin
      open_all();
      ctrl.issue(K_PRE, 2'(b), NA);
      ctrl.idle(2);
      check(bank_precharging_reg, 4'h1 << b);
      ctrl.idle(2);
      check(bank_open_reg, 4'hF & ~(4'h1 << b));
      ctrl.issue(K_PRE, 2'(3 - b), AP);
      ctrl.idle(4);
      check(bank_open_reg, 4'h0);
    end
    check(viol_seen, 1'b0);
  endtask

  task automatic t_bl4();
    ctrl.issue(K_MRS, 2'h0, 14'h0442);
    ctrl.idle(4);
    open_all();
    run_case(K_RD, NA, 2, K_RD, 2'h1, NA, 1'b0, 1'b0);
    run_case(K_RD, NA, 1, K_RD, 2'h1, NA, 1'b1, 1'b0);
    ctrl.issue(K_MRS, 2'h0, 14'h0443);
    ctrl.issue(K_PRE, 2'h0, AP);
    ctrl.idle(4);
  endtask

  task automatic t_interrupt();
    open_all();
    run_case(K_RD, NA, 2, K_RD, 2'h1, AP, 1'b0, 1'b1);
    run_case(K_WR, NA, 2, K_WR, 2'h2, AP, 1'b0, 1'b1);
    run_case(K_RD, NA, 1, K_RD, 2'h0, NA, 1'b1, 1'b0);
    run_case(K_WR, NA, 3, K_WR, 2'h0, NA, 1'b1, 1'b0);
    run_case(K_RD, NA, 2, K_WR, 2'h0, NA, 1'b1, 1'b0);
    run_case(K_WR, NA, 2, K_RD, 2'h0, NA, 1'b1, 1'b0);
    run_case(K_WR, NA, 2, K_PRE, 2'h3, NA, 1'b1, 1'b0);
    run_case(K_RD, NA, 2, K_PRE, 2'h3, NA, 1'b1, 1'b0);
    run_case(K_RD, AP, 2, K_RD, 2'h0, NA, 1'b1, 1'b0);
  endtask

  // burst of eight with one clock of added latency: read close at 5, write close at 10
  task automatic t_autopre();
    open_all();
    ctrl.issue(K_RD, 2'h0, NA);
    ctrl.idle(1);
    check(read_burst_reg, 1'b1);
    ctrl.idle(3);
    check(read_burst_reg, 1'b1);
    ctrl.idle(1);
    check(read_burst_reg, 1'b0);
    ctrl.idle(7);
    check(bank_open_reg[0], 1'b1);
    ctrl.issue(K_RD, 2'h1, AP);
    ctrl.idle(6);
    check(bank_open_reg[1], 1'b1);
    ctrl.idle(4);
    check(bank_open_reg[1], 1'b0);
    ctrl.issue(K_WR, 2'h2, AP);
    ctrl.idle(1);
    check(write_burst_reg, 1'b1);
    ctrl.idle(4);
    check(write_burst_reg, 1'b0);
    ctrl.idle(4);
    check(bank_open_reg[2], 1'b1);
    ctrl.idle(6);
    check(bank_open_reg[2], 1'b0);
  endtask

  task automatic t_recovery();
    viol_seen = 1'b0;
    ctrl.issue(K_WR, 2'h0, NA);
    ctrl.idle(5);
    ctrl.issue(K_PRE, 2'h0, NA);
    ctrl.idle(4);
    check(viol_seen, 1'b1);
    viol_seen = 1'b0;
    ctrl.issue(K_WR, 2'h3, NA);
    ctrl.idle(11);
    ctrl.issue(K_PRE, 2'h3, NA);
    ctrl.idle(4);
    check(viol_seen, 1'b0);
    check(bank_open_reg[3], 1'b0);
    viol_seen = 1'b0;
    ctrl.issue(K_ACT, 2'h1, NA);
    ctrl.issue(K_ACT, 2'h1, NA);
    ctrl.idle(4);
    check(viol_seen, 1'b1);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    t_mode();
    t_precharge();
    t_bl4();
    t_interrupt();
    t_autopre();
    t_recovery();
    summarize();
  end
endmodule
